// File: logic/cbh_pkg.sv
// Purpose: shared constants and carriers for the comm board host bus interface
// Assumes: 20 bit local addresses, 24 bit system addresses, 16 bit data
// Notes: no timing constants are needed; each cycle but prom, latch, doorbell and hole ones runs until its ack, all on one clock
package cbh_pkg;
    localparam int LOC_AW = 20;
    localparam int SYS_AW = 24;
    localparam int DW = 16;
    localparam int IO_AW = 16;
    // quadrant select is the top two local address bits
    localparam logic [1:0] QUAD_RAM = 2'h0;
    localparam logic [1:0] QUAD_HANDLER = 2'h1;
    localparam logic [1:0] QUAD_WINDOW = 2'h2;
    localparam logic [1:0] QUAD_ROM = 2'h3;
    localparam int QUAD_LSB = 18;
    localparam int WIN_SEL_BIT = 17;
    localparam int WIN_OFS_W = 17;
    localparam int WIN_BASE_W = 8;
    localparam int SEG_SHIFT = 16;
    // internal registers sit at the very top of the rom quadrant
    localparam logic [LOC_AW-1:0] INTREG_BASE = 20'hfff00;
    // local io map
    localparam logic [IO_AW-1:0] SYS_IO_LO = 16'h0180;
    localparam logic [IO_AW-1:0] IO_WIN0_LATCH = 16'h0000;
    localparam logic [IO_AW-1:0] IO_WIN1_LATCH = 16'h0002;
    localparam logic [IO_AW-1:0] IO_DOORBELL = 16'h0004;
    localparam logic [IO_AW-1:0] IO_PROM_LO = 16'h0040;
    localparam logic [IO_AW-1:0] IO_PROM_HI = 16'h007f;
    localparam logic [IO_AW-1:0] IO_EXP_LO = 16'h0080;
    localparam logic [IO_AW-1:0] IO_EXP_HI = 16'h00ff;
    localparam int PROM_AW = 5;
    localparam int PROM_DEPTH = 32;
    // doorbell command values
    localparam logic [7:0] CMD_ONE = 8'h01;
    localparam logic [7:0] CMD_TWO = 8'h02;
    localparam logic [7:0] CMD_THREE = 8'h03;
    localparam logic [WIN_BASE_W-1:0] WIN_BASE_RST = 8'h00;
    localparam int DP_BLOCK_SHIFT = 17;
    localparam int DP_SEL_W = 7;

    typedef struct packed {
        logic req;
        logic we;
        logic io;
        logic word;
        logic [LOC_AW-1:0] addr;
        logic [DW-1:0] wdata;
    } cbh_loc_req_s;

    typedef struct packed {
        logic req;
        logic we;
        logic io;
        logic word;
        logic [SYS_AW-1:0] addr;
        logic [DW-1:0] wdata;
    } cbh_sys_req_s;

    typedef struct packed {
        logic ram;
        logic handler;
        logic rom;
        logic intreg;
        logic prom;
        logic exp_mod;
    } cbh_sel_s;
endpackage

// File: logic/cbh_prom.sv
// Purpose: station address prom with registered read data
// Assumes: contents given as a parameter, checksum lives in the last bytes
// Notes: read latency one clock
`timescale 1ns/1ns
module cbh_prom #(
    parameter int AW = cbh_pkg::PROM_AW,
    parameter int DEPTH = cbh_pkg::PROM_DEPTH,
    parameter logic [DEPTH*8-1:0] INIT = '0
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= INIT[rd_addr*8 +: 8];
        end
    end
endmodule

// File: logic/cbh_bridge.sv
// Purpose: local bus decode, system bus windows, dual port slave and doorbell port
// Assumes: one-cycle strobes from local cpu and system bus, both synchronous to ref_clk
// Notes: system bus master cycle ends on sys_ack; arbitration by bus_req/bus_grant
// Operation
// [R1] low quadrant selects local ram
// [R2] second quadrant selects frame handler registers
// [R3] third quadrant holds two equal system windows
// [R4] top quadrant selects rom and internal registers
// [R5] windows reach whole 16 mb system memory
// [R6] window base 64 kb aligned, io latch
// [R7] up to 128 kb ram dual ported
// [R8] master drives 8/16 data, 24 address bits
// [R9] internal registers live in memory map
// [R10] local io 180h..ffffh becomes system io
// [R11] doorbell is system io and local io
// [R12] value 1: local clears host irq; host resets
// [R13] value 2: local raises host irq; host interrupts cpu
// [R14] value 3: local clears own irq; host clears host irq
// [R15] full system bus arbitration for mastership
// [R16] expansion connector 16 bit, 8 bit accepted
// [R17] frame handler dma reaches local ram directly
// [R18] station address prom readable by local io
// [R19] system slave decodes only the doorbell location
// [R20] irq latches hold until matching clear
// [R21] source by port; other values ignored
`timescale 1ns/1ns
module cbh_bridge #(
    parameter logic [cbh_pkg::IO_AW-1:0] DOORBELL_SYS_ADDR = 16'h0100,
    parameter logic [cbh_pkg::DP_SEL_W-1:0] DP_BASE_SEL = 7'h00,
    parameter logic [cbh_pkg::DP_SEL_W-1:0] DP_ENABLE = 7'h7f,
    parameter logic [cbh_pkg::PROM_DEPTH*8-1:0] PROM_INIT = '0
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire cbh_pkg::cbh_loc_req_s loc_req,
    output logic [cbh_pkg::DW-1:0] loc_rdata,
    output logic loc_ready,
    input wire logic dma_req,
    input wire logic dma_we,
    input wire logic [cbh_pkg::QUAD_LSB-1:0] dma_addr,
    output logic dma_grant,
    output cbh_pkg::cbh_sel_s dev_sel,
    output logic [cbh_pkg::LOC_AW-1:0] dev_addr,
    output logic dev_we,
    output logic [cbh_pkg::DW-1:0] dev_wdata,
    output logic dev_byte,
    input wire logic [cbh_pkg::DW-1:0] dev_rdata,
    input wire logic dev_ack,
    input wire logic exp_mod_8bit,
    output logic bus_req,
    input wire logic bus_grant,
    input wire logic bus_busy_in,
    output logic bus_busy_out,
    output cbh_pkg::cbh_sys_req_s sys_mreq,
    input wire logic [cbh_pkg::DW-1:0] sys_mrdata,
    input wire logic sys_ack,
    input wire cbh_pkg::cbh_sys_req_s sys_sreq,
    output logic sys_sel_ram,
    output logic [cbh_pkg::QUAD_LSB-1:0] sys_ram_addr,
    output logic sys_slave_ack,
    output logic host_irq,
    output logic cpu_irq,
    output logic board_reset
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ARB = 4'b0010,
        ST_XFER = 4'b0100,
        ST_LOCAL = 4'b1000
    } cbh_state_e;

    localparam int AW = cbh_pkg::LOC_AW;
    localparam int QL = cbh_pkg::QUAD_LSB;

    cbh_state_e state_q;
    cbh_pkg::cbh_loc_req_s held_q;
    logic [cbh_pkg::WIN_BASE_W-1:0] win_base_q [2];
    logic host_irq_q;
    logic cpu_irq_q;
    logic board_reset_q;
    logic prom_cycle_q;
    logic [7:0] prom_rdata;

    function automatic logic [1:0] quad_of(input logic [AW-1:0] a);
        return a[AW-1:QL];
    endfunction

    function automatic logic in_range(input logic [cbh_pkg::IO_AW-1:0] a,
                                      input logic [cbh_pkg::IO_AW-1:0] lo,
                                      input logic [cbh_pkg::IO_AW-1:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    // local request classification
    logic [cbh_pkg::IO_AW-1:0] io_a;
    logic is_sys_io;
    logic is_win;
    logic is_doorbell_wr;
    logic is_latch_wr [2];
    logic to_sys;
    logic win_idx;
    logic [cbh_pkg::SYS_AW-1:0] win_addr;
    always_comb begin
        io_a = loc_req.addr[cbh_pkg::IO_AW-1:0];
        is_sys_io = loc_req.io && in_range(io_a, cbh_pkg::SYS_IO_LO, 16'hffff); // see [R10]
        is_win = !loc_req.io && quad_of(loc_req.addr) == cbh_pkg::QUAD_WINDOW; // see [R3]
        is_doorbell_wr = loc_req.io && loc_req.we && io_a == cbh_pkg::IO_DOORBELL; // see [R11]
        is_latch_wr[0] = loc_req.io && loc_req.we && io_a == cbh_pkg::IO_WIN0_LATCH; // see [R6]
        is_latch_wr[1] = loc_req.io && loc_req.we && io_a == cbh_pkg::IO_WIN1_LATCH;
        to_sys = is_sys_io || is_win;
        win_idx = loc_req.addr[cbh_pkg::WIN_SEL_BIT];
        // base in 64 kb steps plus 128 kb offset reaches all 24 bits; see [R5]
        win_addr = {win_base_q[win_idx], {cbh_pkg::SEG_SHIFT{1'b0}}}
                   + {7'h00, loc_req.addr[cbh_pkg::WIN_OFS_W-1:0]};
    end

    // window base latches, one per window
    generate
        for (genvar w = 0; w < 2; w++) begin : g_win
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    win_base_q[w] <= cbh_pkg::WIN_BASE_RST;
                end else if (loc_req.req && state_q == ST_IDLE && is_latch_wr[w]) begin
                    win_base_q[w] <= loc_req.wdata[cbh_pkg::WIN_BASE_W-1:0]; // see [R6]
                end
            end
        end
    endgenerate

    // main local cycle sequencer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            held_q <= '0;
            sys_mreq <= '0;
            bus_req <= 1'b0;
            bus_busy_out <= 1'b0;
            loc_ready <= 1'b0;
            loc_rdata <= '0;
            dev_sel <= '0;
            dev_addr <= '0;
            dev_we <= 1'b0;
            dev_wdata <= '0;
            dev_byte <= 1'b0;
            prom_cycle_q <= 1'b0;
        end else begin
            loc_ready <= 1'b0;
            prom_cycle_q <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    if (loc_req.req) begin
                        held_q <= loc_req;
                        dev_addr <= loc_req.addr;
                        dev_we <= loc_req.we;
                        dev_wdata <= loc_req.wdata;
                        if (to_sys) begin
                            bus_req <= 1'b1; // see [R15]
                            sys_mreq.we <= loc_req.we;
                            sys_mreq.io <= loc_req.io;
                            sys_mreq.word <= loc_req.word; // see [R8]
                            sys_mreq.wdata <= loc_req.wdata;
                            sys_mreq.addr <= loc_req.io ? {8'h00, io_a} : win_addr;
                            state_q <= ST_ARB;
                        end else if (loc_req.io) begin
                            if (in_range(io_a, cbh_pkg::IO_PROM_LO, cbh_pkg::IO_PROM_HI)) begin
                                dev_sel.prom <= 1'b1; // see [R18]
                                prom_cycle_q <= 1'b1;
                                state_q <= ST_LOCAL;
                            end else if (in_range(io_a, cbh_pkg::IO_EXP_LO,
                                                  cbh_pkg::IO_EXP_HI)) begin
                                dev_sel.exp_mod <= 1'b1; // see [R16]
                                dev_byte <= exp_mod_8bit | !loc_req.word;
                                state_q <= ST_LOCAL;
                            end else begin
                                // latches, doorbell and holes finish at once
                                loc_rdata <= '0;
                                loc_ready <= 1'b1;
                            end
                        end else begin
                            unique case (quad_of(loc_req.addr))
                                cbh_pkg::QUAD_RAM: dev_sel.ram <= 1'b1; // see [R1]
                                cbh_pkg::QUAD_HANDLER: dev_sel.handler <= 1'b1; // see [R2]
                                cbh_pkg::QUAD_ROM: begin
                                    // internal regs in memory space keep io free; see [R9]
                                    if (loc_req.addr >= cbh_pkg::INTREG_BASE) begin
                                        dev_sel.intreg <= 1'b1;
                                    end else begin
                                        dev_sel.rom <= 1'b1; // see [R4]
                                    end
                                end
                                cbh_pkg::QUAD_WINDOW: dev_sel.ram <= 1'b0;
                            endcase
                            dev_byte <= !loc_req.word;
                            state_q <= ST_LOCAL;
                        end
                    end
                end
                ST_ARB: begin
                    // wait for grant and a free bus before driving a cycle
                    if (bus_grant && !bus_busy_in) begin
                        bus_busy_out <= 1'b1;
                        sys_mreq.req <= 1'b1;
                        state_q <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    sys_mreq.req <= 1'b0;
                    if (sys_ack) begin
                        loc_rdata <= sys_mreq.word ? sys_mrdata : {8'h00, sys_mrdata[7:0]};
                        loc_ready <= 1'b1;
                        bus_req <= 1'b0;
                        bus_busy_out <= 1'b0;
                        state_q <= ST_IDLE;
                    end
                end
                ST_LOCAL: begin
                    if (dev_sel.prom && !prom_cycle_q) begin
                        loc_rdata <= {8'h00, prom_rdata};
                        loc_ready <= 1'b1;
                        dev_sel <= '0;
                        state_q <= ST_IDLE;
                    end else if (!dev_sel.prom && dev_ack) begin
                        // 8 bit module data sits in the low lane only
                        loc_rdata <= dev_byte ? {8'h00, dev_rdata[7:0]} : dev_rdata;
                        loc_ready <= 1'b1;
                        dev_sel <= '0;
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    cbh_prom #(
        .AW(cbh_pkg::PROM_AW),
        .DEPTH(cbh_pkg::PROM_DEPTH),
        .INIT(PROM_INIT)
    ) u_prom (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .rd_addr(held_q.addr[cbh_pkg::PROM_AW-1:0]),
        .rd_data(prom_rdata)
    );

    // frame handler dma to local ram, granted only when the cpu is not on it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dma_grant <= 1'b0;
        end else begin
            dma_grant <= dma_req && !(state_q == ST_LOCAL && dev_sel.ram); // see [R17]
        end
    end

    // system bus slave: dual port ram and the single doorbell location
    logic sreq_dp;
    logic sreq_bell;
    logic [cbh_pkg::DP_SEL_W-1:0] dp_blk;
    always_comb begin
        dp_blk = sys_sreq.addr[cbh_pkg::SYS_AW-1:cbh_pkg::DP_BLOCK_SHIFT];
        sreq_dp = sys_sreq.req && !sys_sreq.io && (dp_blk & DP_ENABLE) == DP_BASE_SEL; // see [R7]
        sreq_bell = sys_sreq.req && sys_sreq.io
                    && sys_sreq.addr[cbh_pkg::IO_AW-1:0] == DOORBELL_SYS_ADDR; // see [R19]
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_sel_ram <= 1'b0;
            sys_ram_addr <= '0;
            sys_slave_ack <= 1'b0;
        end else begin
            sys_sel_ram <= sreq_dp;
            sys_ram_addr <= {1'b0, sys_sreq.addr[cbh_pkg::DP_BLOCK_SHIFT-1:0]};
            sys_slave_ack <= sreq_dp || sreq_bell;
        end
    end

    // doorbell command decode; source is known by the port it came in on
    logic loc_bell;
    logic [7:0] loc_val;
    logic [7:0] host_val;
    always_comb begin
        loc_bell = loc_req.req && state_q == ST_IDLE && is_doorbell_wr; // see [R21]
        loc_val = loc_bell ? loc_req.wdata[7:0] : 8'h00;
        host_val = (sreq_bell && sys_sreq.we) ? sys_sreq.wdata[7:0] : 8'h00;
    end

    // host irq: set wins if local sets while host clears
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_irq_q <= 1'b0;
        end else if (loc_val == cbh_pkg::CMD_TWO) begin
            host_irq_q <= 1'b1; // see [R13] [R20]
        end else if (loc_val == cbh_pkg::CMD_ONE || host_val == cbh_pkg::CMD_THREE) begin
            host_irq_q <= 1'b0; // see [R12] [R14]
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_irq_q <= 1'b0;
        end else if (host_val == cbh_pkg::CMD_TWO) begin
            cpu_irq_q <= 1'b1; // see [R13] [R20]
        end else if (loc_val == cbh_pkg::CMD_THREE) begin
            cpu_irq_q <= 1'b0; // see [R14]
        end
    end

    // one-cycle board reset pulse; outside logic stretches it as needed
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            board_reset_q <= 1'b0;
        end else begin
            board_reset_q <= host_val == cbh_pkg::CMD_ONE; // see [R12]
        end
    end

    assign host_irq = host_irq_q;
    assign cpu_irq = cpu_irq_q;
    assign board_reset = board_reset_q;
endmodule

// File: tb/cbh_bridge_chk.sv
// Purpose: port level checker for cbh_bridge
// Assumes: one clock, async active low reset
// Notes: doorbell effects may land one or two cycles after the write
`timescale 1ns/1ns
module cbh_bridge_chk #(
    parameter logic [cbh_pkg::IO_AW-1:0] DOORBELL_SYS_ADDR = 16'h0100
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic dma_req,
    input wire logic dma_grant,
    input wire cbh_pkg::cbh_sel_s dev_sel,
    input wire logic [cbh_pkg::LOC_AW-1:0] dev_addr,
    input wire logic bus_grant,
    input wire logic bus_busy_in,
    input wire logic bus_busy_out,
    input wire cbh_pkg::cbh_sys_req_s sys_mreq,
    input wire cbh_pkg::cbh_sys_req_s sys_sreq,
    input wire logic sys_slave_ack,
    input wire logic host_irq,
    input wire logic cpu_irq,
    input wire logic board_reset
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire logic hw = sys_sreq.req && sys_sreq.we && sys_sreq.io
        && sys_sreq.addr[15:0] == DOORBELL_SYS_ADDR;
    wire logic [7:0] hv = sys_sreq.wdata[7:0];
    chk_ram_quad:
        assert property (dev_sel.ram |-> dev_addr[19:18] == cbh_pkg::QUAD_RAM)
        else $error("ram select outside low quadrant");
    chk_handler_quad:
        assert property (dev_sel.handler |-> dev_addr[19:18] == cbh_pkg::QUAD_HANDLER)
        else $error("handler select outside second quadrant");
    chk_rom_quad:
        assert property ((dev_sel.rom || dev_sel.intreg) |-> dev_addr[19:18] == 2'h3)
        else $error("rom select outside top quadrant");
    chk_grant_first:
        assert property ($rose(sys_mreq.req) |-> $past(bus_grant && !bus_busy_in) && bus_busy_out)
        else $error("master cycle without mastership");
    chk_io_range:
        assert property (sys_mreq.req && sys_mreq.io |-> sys_mreq.addr[23:16] == 8'h00
            && sys_mreq.addr[15:0] >= cbh_pkg::SYS_IO_LO)
        else $error("system io cycle outside forwarded range");
    chk_slave_hit:
        assert property (sys_slave_ack |-> $past(sys_sreq.req))
        else $error("slave ack without request");
    chk_host_reset:
        assert property (hw && hv == 8'h01 |-> ##[1:2] board_reset)
        else $error("host reset command lost");
    chk_host_clear:
        assert property (hw && hv == 8'h03 |-> ##[1:2] !host_irq)
        else $error("host clear command lost");
    chk_cpu_irq_src:
        assert property ($rose(cpu_irq) |-> $past(hw && hv == 8'h02) || $past(hw && hv == 8'h02, 2))
        else $error("cpu interrupt without host command");
    chk_dma_cause:
        assert property (dma_grant |-> $past(dma_req))
        else $error("dma grant without request");
endmodule

// File: tb/cbh_host_model.sv
// Purpose: system bus arbiter and memory standing in for the host side
// Assumes: one master cycle outstanding at a time
// Notes: slow holds the bus busy and stretches grant and ack
`timescale 1ns/1ns
module cbh_host_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic slow,
    input wire logic bus_req,
    output logic bus_grant,
    output logic bus_busy_in,
    input wire cbh_pkg::cbh_sys_req_s sys_mreq,
    output logic [cbh_pkg::DW-1:0] sys_mrdata,
    output logic sys_ack,
    output cbh_pkg::cbh_sys_req_s seen_q
);
    logic [2:0] gcnt_q;
    logic [2:0] wait_q;
    logic busy_q;
    logic [cbh_pkg::DW-1:0] rd_q;
    // in slow mode another master holds the bus until we grant
    assign bus_busy_in = slow && !bus_grant;
    // released data lines show the inverse of the last word
    assign sys_mrdata = sys_ack ? rd_q : ~rd_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gcnt_q <= 3'h0;
            bus_grant <= 1'b0;
        end else begin
            gcnt_q <= !bus_req ? 3'h0 : (gcnt_q == 3'h7 ? gcnt_q : gcnt_q + 3'h1);
            bus_grant <= bus_req && (!slow || gcnt_q > 3'h2);
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            wait_q <= 3'h0;
            sys_ack <= 1'b0;
            seen_q <= '0;
            rd_q <= '0;
        end else begin
            sys_ack <= 1'b0;
            if (sys_mreq.req) begin
                busy_q <= 1'b1;
                wait_q <= slow ? 3'h4 : 3'h0;
                seen_q <= sys_mreq;
            end else if (busy_q && wait_q != 3'h0) begin
                wait_q <= wait_q - 3'h1;
            end else if (busy_q) begin
                busy_q <= 1'b0;
                sys_ack <= 1'b1;
                rd_q <= seen_q.addr[15:0] ^ 16'ha5c3;
            end
        end
    end
endmodule

// File: tb/testbench.sv
// Purpose: self-checking bench for cbh_bridge
// Assumes: host model on the system bus, bench answers local devices
// Notes: decode table first, then 8 bit expansion read, windows, doorbell, dual port, dma, reset
`timescale 1ns/1ns
module testbench;
    typedef struct packed {
        logic io;
        logic [19:0] addr;
        cbh_pkg::cbh_sel_s sel;
        logic sys;
        logic [23:0] saddr;
    } cbh_row_s;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic slow = 1'b0;
    logic dma_req = 1'b0;
    logic dev_ack = 1'b0;
    logic exp_mod_8bit = 1'b0;
    logic [15:0] dev_rdata = 16'h0000;
    cbh_pkg::cbh_loc_req_s loc_req = '0;
    cbh_pkg::cbh_sys_req_s sys_sreq = '0;
    cbh_pkg::cbh_sys_req_s sys_mreq, seen;
    cbh_pkg::cbh_sel_s dev_sel;
    cbh_pkg::cbh_sel_s last_sel = '0;
    logic [15:0] loc_rdata, dev_wdata, sys_mrdata;
    logic [19:0] dev_addr;
    logic [17:0] sys_ram_addr;
    logic [17:0] last_ram = '0;
    logic loc_ready, dma_grant, dev_we, dev_byte, bus_req, bus_grant, bus_busy_in;
    logic bus_busy_out, sys_ack, sys_sel_ram, sys_slave_ack, host_irq, cpu_irq, board_reset;
    int n_errors = 0;
    int check_count = 0;
    int n_sys = 0;
    int n_ack = 0;
    int n_brst = 0;
    int k0;
    cbh_row_s rows [10] = '{
        '{1'b0, 20'h01234, 6'h20, 1'b0, 24'h0}, '{1'b0, 20'h45678, 6'h10, 1'b0, 24'h0},
        '{1'b0, 20'hc0010, 6'h08, 1'b0, 24'h0}, '{1'b0, 20'hfff04, 6'h04, 1'b0, 24'h0},
        '{1'b1, 20'h00080, 6'h01, 1'b0, 24'h0}, '{1'b0, 20'h80000, 6'h00, 1'b1, 24'h0},
        '{1'b0, 20'ha0004, 6'h00, 1'b1, 24'h4}, '{1'b1, 20'h00180, 6'h00, 1'b1, 24'h180},
        '{1'b1, 20'h0ffff, 6'h00, 1'b1, 24'hffff}, '{1'b1, 20'h0017f, 6'h00, 1'b0, 24'h0}};
    always #25 ref_clk = ~ref_clk;
    cbh_bridge cbh_bridge_i (.ref_clk, .rst_n, .loc_req, .loc_rdata, .loc_ready, .dma_req,
        .dma_we(1'b0), .dma_addr(18'h00000), .dma_grant, .dev_sel, .dev_addr, .dev_we,
        .dev_wdata, .dev_byte, .dev_rdata, .dev_ack, .exp_mod_8bit, .bus_req, .bus_grant,
        .bus_busy_in, .bus_busy_out, .sys_mreq, .sys_mrdata, .sys_ack, .sys_sreq, .sys_sel_ram,
        .sys_ram_addr, .sys_slave_ack, .host_irq, .cpu_irq, .board_reset);
    cbh_host_model cbh_host_model_i (.ref_clk, .rst_n, .slow, .bus_req, .bus_grant,
        .bus_busy_in, .sys_mreq, .sys_mrdata, .sys_ack, .seen_q(seen));
    // prom answers on its own, so no device ack for it
    always @(posedge ref_clk) begin
        dev_ack <= dev_sel != '0 && !dev_sel.prom && !dev_ack;
        dev_rdata <= dev_sel != '0 ? dev_addr[15:0] ^ 16'h0f0f : ~dev_rdata;
        if (dev_sel != '0) last_sel <= dev_sel;
        if (sys_mreq.req) n_sys <= n_sys + 1;
        if (sys_slave_ack) n_ack <= n_ack + 1;
        if (sys_sel_ram) last_ram <= sys_ram_addr;
        if (board_reset) n_brst <= n_brst + 1;
    end
    // wide enough that packed flag groups keep their top bits
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t value mismatch got %h want %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        if (n_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic loc_op(input logic we, input logic io, input logic [19:0] a,
        input logic [15:0] d);
        int i;
        @(posedge ref_clk);
        loc_req <= '{req:1'b1, we:we, io:io, word:1'b1, addr:a, wdata:d};
        @(posedge ref_clk);
        loc_req <= {1'b0, ~loc_req[$bits(loc_req)-2:0]};
        for (i = 0; i < 60 && loc_ready !== 1'b1; i++) @(negedge ref_clk);
        if (loc_ready !== 1'b1) begin
            n_errors++;
            conclude();
        end
    endtask
    task automatic host_op(input logic io, input logic we, input logic [23:0] a,
        input logic [7:0] d);
        @(posedge ref_clk);
        sys_sreq <= '{req:1'b1, we:we, io:io, word:1'b0, addr:a, wdata:{8'h00, d}};
        @(posedge ref_clk);
        sys_sreq <= {1'b0, ~sys_sreq[$bits(sys_sreq)-2:0]};
        repeat (3) @(posedge ref_clk);
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        check({host_irq, cpu_irq, bus_req, loc_ready, board_reset, dma_grant}, 0);
        rst_n <= 1'b1;
        foreach (rows[k]) begin
            slow <= k % 2;
            last_sel = '0;
            k0 = n_sys;
            loc_op(1'b0, rows[k].io, rows[k].addr, 16'h0000);
            check(last_sel, rows[k].sel);
            check(n_sys - k0, rows[k].sys);
            if (rows[k].sys) check(seen.addr, rows[k].saddr);
            if (rows[k].sys) check(loc_rdata, rows[k].saddr[15:0] ^ 16'ha5c3);
            if (rows[k].sel != '0) check(loc_rdata, rows[k].addr[15:0] ^ 16'h0f0f);
        end
        exp_mod_8bit <= 1'b1;
        loc_op(1'b0, 1'b1, 20'h00081, 16'h0000);
        check(loc_rdata, 16'h008e);
        loc_op(1'b1, 1'b1, 20'h00000, 16'h00fe);
        loc_op(1'b1, 1'b1, 20'h00002, 16'h0012);
        loc_op(1'b0, 1'b0, 20'h9fffe, 16'h0000);
        check(seen.addr, 24'hfffffe);
        loc_op(1'b1, 1'b0, 20'ha0010, 16'hbeef);
        check({seen.we, seen.word, seen.addr, seen.wdata}, {2'b11, 24'h120010, 16'hbeef});
        loc_op(1'b1, 1'b1, 20'h00004, 16'h0002);
        repeat (2) @(posedge ref_clk);
        check(host_irq, 1'b1);
        host_op(1'b1, 1'b1, 24'h000100, 8'h02);
        check({host_irq, cpu_irq, n_ack}, {2'b11, 32'd1});
        host_op(1'b1, 1'b1, 24'h000100, 8'h03);
        check({host_irq, cpu_irq}, 2'b01);
        host_op(1'b1, 1'b1, 24'h000100, 8'h05);
        host_op(1'b1, 1'b1, 24'h000104, 8'h03);
        check({host_irq, cpu_irq, n_ack}, {2'b01, 32'd3});
        loc_op(1'b1, 1'b1, 20'h00004, 16'h0003);
        loc_op(1'b1, 1'b1, 20'h00004, 16'h0002);
        loc_op(1'b1, 1'b1, 20'h00004, 16'h0001);
        repeat (2) @(posedge ref_clk);
        check({host_irq, cpu_irq, n_brst}, 0);
        host_op(1'b1, 1'b1, 24'h000100, 8'h01);
        check(n_brst, 1);
        host_op(1'b0, 1'b0, 24'h001234, 8'h00);
        host_op(1'b0, 1'b0, 24'h020000, 8'h00);
        check({last_ram, n_ack}, {18'h01234, 32'd5});
        dma_req <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check(dma_grant, 1'b1);
        dma_req <= 1'b0;
        loc_op(1'b1, 1'b1, 20'h00004, 16'h0002);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check({host_irq, cpu_irq, bus_req, sys_slave_ack}, 0);
        conclude();
    end
endmodule
bind cbh_bridge cbh_bridge_chk #(.DOORBELL_SYS_ADDR(DOORBELL_SYS_ADDR)) cbh_bridge_chk_i (
    .ref_clk, .rst_n, .dma_req, .dma_grant, .dev_sel, .dev_addr, .bus_grant, .bus_busy_in,
    .bus_busy_out, .sys_mreq, .sys_sreq, .sys_slave_ack, .host_irq, .cpu_irq, .board_reset);
